// [common/pfm_pkg.sv]
package pfm_pkg;

  // Pin population
  localparam int unsigned NPIN      = 8;
  localparam int unsigned NFUNC     = 3;
  localparam logic [2:0]  PIN_SCL   = 3'h5;
  localparam logic [2:0]  PIN_SDA   = 3'h6;
  localparam logic [2:0]  PIN_ANA   = 3'h7;

  // Register byte offsets
  localparam logic [7:0] OFF_CFG_P2_6   = 8'h00;
  localparam logic [7:0] OFF_RSVD_04    = 8'h04;
  localparam logic [7:0] OFF_CFG_P2_0   = 8'h08;
  localparam logic [7:0] OFF_CFG_RST0_0 = 8'h0c;
  localparam logic [7:0] OFF_CFG_P0_1   = 8'h10;
  localparam logic [7:0] OFF_CFG_P1_8   = 8'h14;
  localparam logic [7:0] OFF_CFG_SCL    = 8'h30;
  localparam logic [7:0] OFF_CFG_SDA    = 8'h34;
  localparam logic [7:0] OFF_CFG_ANA    = 8'h6c;
  localparam logic [7:0] OFF_LOC        = 8'hb0;
  localparam logic [7:0] OFF_DIR        = 8'hc0;
  localparam logic [7:0] OFF_GPIO_OUT   = 8'hc4;
  localparam logic [7:0] OFF_PIN_STATE  = 8'hc8;

  // Pin configuration field positions
  localparam int unsigned F_PIN_FUNCTION_SELECT_LSB = 0;
  localparam int unsigned F_MODE_LSB = 3;
  localparam int unsigned F_HYST     = 5;
  localparam int unsigned F_RSVD1    = 6;
  localparam int unsigned F_DIGITAL  = 7;
  localparam int unsigned F_I2C_LSB  = 8;

  // Reset values
  localparam logic [31:0] CFG_RESET = 32'h0000_00d0;
  localparam logic [7:0]  LOC_RESET = 8'h00;
  localparam logic [7:0]  DIR_RESET = 8'h00;
  localparam logic [7:0]  OUT_RESET = 8'h00;

  // Function select codes
  localparam logic [2:0] PIN_FUNCTION_SELECT_GPIO = 3'h0;
  localparam logic [2:0] PIN_FUNCTION_SELECT_I2C  = 3'h1;

  // Pull mode codes
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_PD   = 2'h1;
  localparam logic [1:0] MODE_PU   = 2'h2;
  localparam logic [1:0] MODE_RPT  = 2'h3;

  // I2C mode codes
  localparam logic [1:0] I2C_STD  = 2'h0;
  localparam logic [1:0] I2C_GPIO = 2'h1;
  localparam logic [1:0] I2C_FMP  = 2'h2;

  // Candidate pins per multiplexed input, 3 bits per location code
  localparam logic [11:0] LOC_SCK_PINS = {3'h1, 3'h7, 3'h4, 3'h1};
  localparam logic [11:0] LOC_DSR_PINS = {3'h2, 3'h3, 3'h2, 3'h2};
  localparam logic [11:0] LOC_DCD_PINS = {3'h3, 3'h0, 3'h4, 3'h3};
  localparam logic [11:0] LOC_RI_PINS  = {3'h0, 3'h2, 3'h0, 3'h0};

endpackage

// [src/pfm_pad_config.sv]
`timescale 1ns/1ps
// What this block does
// - Function code 000 gives the pin to GPIO; codes 1 to 3 route to a peripheral slot.
// - A GPIO pin takes its direction from its port direction register bit.
// - A peripheral pin's output enable comes from the selected peripheral itself.
// - Direction bits have no effect on pins assigned to a peripheral.
// - Pull mode offers pull-up, pull-down, none and repeater; reset selects pull-up.
// - Repeater enables pull-up when pin reads high, pull-down when it reads low.
// - Repeater retention may be dropped during deepest power-down.
// - Each pin selects hysteresis or plain input buffer.
// - Analog mode on an analog pin disconnects the digital receiver.
// - Analog mode makes hysteresis and pull settings ignored.
// - Analog mode control exists only on pins with a converter input.
// - Analog mode setting has no effect on pins without an analog function.
// - I2C pins choose standard/fast filtered, fast-plus filtered, or plain unfiltered.
// - Fast-plus drives open-drain high-current sinks with glitch filter on.
// - Exactly one configuration register exists per port pin.
// - Location select picks the pin feeding serial clock and modem status inputs.
// - Pin configuration registers are read/write and reset to 0xD0.
module pfm_pad_config (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Power state
  input  wire logic        deep_power_down,
  // Pads
  input  wire logic [7:0]  pad_in,
  output logic [7:0]       pad_out,
  output logic [7:0]       pad_oe_n,
  output logic [7:0]       pad_pull_up_en,
  output logic [7:0]       pad_pull_down_en,
  output logic [7:0]       pad_hyst_en,
  output logic [7:0]       pad_rx_en,
  output logic [7:0]       pad_filter_en,
  output logic [7:0]       pad_high_sink_en,
  output logic [7:0]       pad_analog_en,
  // GPIO side
  output logic [7:0]       gpio_in,
  // Peripheral side, three function slots per pin
  input  wire logic [23:0] periph_out,
  input  wire logic [23:0] periph_oe,
  output logic [7:0]       periph_in,
  output logic             serial_port0_clock_input,
  output logic             modem_dataset_ready_input,
  output logic             modem_carrier_detect_input,
  output logic             modem_ring_input
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Maps a byte offset to a pin index; valid flag clear when unmapped
  function automatic logic [3:0] pfm_cfg_index(input logic [7:0] off);
    case (off)
      pfm_pkg::OFF_CFG_P2_6:   pfm_cfg_index = 4'h8;
      pfm_pkg::OFF_CFG_P2_0:   pfm_cfg_index = 4'h9;
      pfm_pkg::OFF_CFG_RST0_0: pfm_cfg_index = 4'ha;
      pfm_pkg::OFF_CFG_P0_1:   pfm_cfg_index = 4'hb;
      pfm_pkg::OFF_CFG_P1_8:   pfm_cfg_index = 4'hc;
      pfm_pkg::OFF_CFG_SCL:    pfm_cfg_index = 4'hd;
      pfm_pkg::OFF_CFG_SDA:    pfm_cfg_index = 4'he;
      pfm_pkg::OFF_CFG_ANA:    pfm_cfg_index = 4'hf;
      default:                 pfm_cfg_index = 4'h0;
    endcase
  endfunction

  // Picks one candidate pin of a location table
  function automatic logic pfm_loc_pick(input logic [11:0] table_pins,
                                        input logic [1:0]  code,
                                        input logic [7:0]  pins);
    logic [2:0] idx;
    idx = table_pins[3*code +: 3];
    pfm_loc_pick = pins[idx];
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] pfm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    pfm_merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [2:0]  pin_function_select_sel     [pfm_pkg::NPIN];
  logic [1:0]  pull_mode    [pfm_pkg::NPIN];
  logic        hyst_sel     [pfm_pkg::NPIN];
  logic        digital_mode [pfm_pkg::NPIN];
  logic [1:0]  i2c_mode     [pfm_pkg::NPIN];
  logic [7:0]  input_location_select;
  logic [7:0]  port_direction_reg;
  logic [7:0]  gpio_out_reg;
  logic        ack;

  logic        req;
  logic        wr_now;
  logic [3:0]  cfg_hit;
  logic [31:0] cfg_word [pfm_pkg::NPIN];
  logic [31:0] next_readdata;
  logic [31:0] wr_val;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer

  // Holding waitrequest for one cycle lets read data come from a flop
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_now          = avs_write & ack;
  assign cfg_hit         = pfm_cfg_index(avs_address);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Readback view of each pin register
  always_comb begin
    for (int p = 0; p < pfm_pkg::NPIN; p++) begin
      cfg_word[p] = 32'h0000_0000;
      cfg_word[p][pfm_pkg::F_PIN_FUNCTION_SELECT_LSB +: 3] = pin_function_select_sel[p];
      cfg_word[p][pfm_pkg::F_MODE_LSB +: 2] = pull_mode[p];
      cfg_word[p][pfm_pkg::F_HYST]          = hyst_sel[p];
      cfg_word[p][pfm_pkg::F_RSVD1]         = 1'b1;
      cfg_word[p][pfm_pkg::F_DIGITAL]       = digital_mode[p];
      cfg_word[p][pfm_pkg::F_I2C_LSB +: 2]  = i2c_mode[p];
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (cfg_hit[3]) begin
      next_readdata = cfg_word[cfg_hit[2:0]];
    end else begin
      case (avs_address)
        pfm_pkg::OFF_LOC:       next_readdata = {24'h00_0000, input_location_select};
        pfm_pkg::OFF_DIR:       next_readdata = {24'h00_0000, port_direction_reg};
        pfm_pkg::OFF_GPIO_OUT:  next_readdata = {24'h00_0000, gpio_out_reg};
        pfm_pkg::OFF_PIN_STATE: next_readdata = {24'h00_0000, pad_in};
        default:                next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin configuration registers

  always_comb begin
    wr_val = pfm_merge(cfg_word[cfg_hit[2:0]], avs_writedata, avs_byteenable);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < pfm_pkg::NPIN; p++) begin
        pin_function_select_sel[p]     <= pfm_pkg::CFG_RESET[pfm_pkg::F_PIN_FUNCTION_SELECT_LSB +: 3];
        pull_mode[p]    <= pfm_pkg::CFG_RESET[pfm_pkg::F_MODE_LSB +: 2];
        hyst_sel[p]     <= pfm_pkg::CFG_RESET[pfm_pkg::F_HYST];
        digital_mode[p] <= pfm_pkg::CFG_RESET[pfm_pkg::F_DIGITAL];
        i2c_mode[p]     <= pfm_pkg::CFG_RESET[pfm_pkg::F_I2C_LSB +: 2];
      end
    end else if (wr_now && cfg_hit[3]) begin
      pin_function_select_sel[cfg_hit[2:0]]  <= wr_val[pfm_pkg::F_PIN_FUNCTION_SELECT_LSB +: 3];
      pull_mode[cfg_hit[2:0]] <= wr_val[pfm_pkg::F_MODE_LSB +: 2];
      hyst_sel[cfg_hit[2:0]]  <= wr_val[pfm_pkg::F_HYST];
      // Only the converter pin stores the analog control
      if (cfg_hit[2:0] == pfm_pkg::PIN_ANA) begin
        digital_mode[cfg_hit[2:0]] <= wr_val[pfm_pkg::F_DIGITAL];
      end
      // Only the two I2C pins store the I2C mode field
      if (cfg_hit[2:0] == pfm_pkg::PIN_SCL || cfg_hit[2:0] == pfm_pkg::PIN_SDA) begin
        i2c_mode[cfg_hit[2:0]] <= wr_val[pfm_pkg::F_I2C_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other software registers

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_location_select <= pfm_pkg::LOC_RESET;
      port_direction_reg    <= pfm_pkg::DIR_RESET;
      gpio_out_reg          <= pfm_pkg::OUT_RESET;
    end else if (wr_now && avs_byteenable[0]) begin
      case (avs_address)
        pfm_pkg::OFF_LOC:      input_location_select <= avs_writedata[7:0];
        pfm_pkg::OFF_DIR:      port_direction_reg    <= avs_writedata[7:0];
        pfm_pkg::OFF_GPIO_OUT: gpio_out_reg          <= avs_writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control

  // All pad controls are registered; a one-cycle lag on a mode change is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_out          <= 8'h00;
      pad_oe_n         <= 8'hff;
      pad_pull_up_en   <= 8'h00;
      pad_pull_down_en <= 8'h00;
      pad_hyst_en      <= 8'h00;
      pad_rx_en        <= 8'h00;
      pad_filter_en    <= 8'h00;
      pad_high_sink_en <= 8'h00;
      pad_analog_en    <= 8'h00;
    end else begin
      for (int p = 0; p < pfm_pkg::NPIN; p++) begin
        logic analog;
        logic is_i2c_pin;
        logic [1:0] slot;
        logic drv_val;
        logic drv_en;
        analog     = 1'b0;
        is_i2c_pin = (p == int'(pfm_pkg::PIN_SCL)) || (p == int'(pfm_pkg::PIN_SDA));
        slot       = 2'h0;
        drv_val    = 1'b0;
        drv_en     = 1'b0;
        // Analog control only acts on the converter pin
        if (p == int'(pfm_pkg::PIN_ANA)) begin
          analog = ~digital_mode[p];
        end
        if (pin_function_select_sel[p] == pfm_pkg::PIN_FUNCTION_SELECT_GPIO) begin
          drv_val = gpio_out_reg[p];
          drv_en  = port_direction_reg[p];
        end else if (pin_function_select_sel[p] <= 3'(pfm_pkg::NFUNC)) begin
          slot    = 2'(pin_function_select_sel[p] - 3'h1);
          drv_val = periph_out[p*pfm_pkg::NFUNC + int'(slot)];
          // Direction register not consulted here
          drv_en  = periph_oe[p*pfm_pkg::NFUNC + int'(slot)];
        end
        // Open-drain: only a low level is driven
        if (is_i2c_pin && pin_function_select_sel[p] == pfm_pkg::PIN_FUNCTION_SELECT_I2C &&
            i2c_mode[p] != pfm_pkg::I2C_GPIO) begin
          drv_en  = drv_en & ~drv_val;
          drv_val = 1'b0;
        end
        pad_out[p]  <= drv_val;
        pad_oe_n[p] <= ~drv_en;
        pad_high_sink_en[p] <= is_i2c_pin && pin_function_select_sel[p] == pfm_pkg::PIN_FUNCTION_SELECT_I2C &&
                               i2c_mode[p] == pfm_pkg::I2C_FMP;
        // Filter on in both filtered I2C modes, also under GPIO use
        pad_filter_en[p] <= is_i2c_pin && (i2c_mode[p] == pfm_pkg::I2C_STD ||
                                           i2c_mode[p] == pfm_pkg::I2C_FMP);
        pad_analog_en[p] <= analog;
        pad_rx_en[p]     <= ~analog;
        pad_hyst_en[p]   <= hyst_sel[p] & ~analog;
        case (pull_mode[p])
          pfm_pkg::MODE_PU: begin
            pad_pull_up_en[p]   <= ~analog;
            pad_pull_down_en[p] <= 1'b0;
          end
          pfm_pkg::MODE_PD: begin
            pad_pull_up_en[p]   <= 1'b0;
            pad_pull_down_en[p] <= ~analog;
          end
          pfm_pkg::MODE_RPT: begin
            // Keeper follows the pin; dropped in deepest power-down
            pad_pull_up_en[p]   <= ~analog & ~deep_power_down & pad_in[p];
            pad_pull_down_en[p] <= ~analog & ~deep_power_down & ~pad_in[p];
          end
          default: begin
            pad_pull_up_en[p]   <= 1'b0;
            pad_pull_down_en[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path and input routing

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_in   <= 8'h00;
      periph_in <= 8'h00;
    end else begin
      for (int p = 0; p < pfm_pkg::NPIN; p++) begin
        logic rx;
        rx = pad_in[p] & ~(p == int'(pfm_pkg::PIN_ANA) && !digital_mode[p]);
        gpio_in[p]   <= rx;
        periph_in[p] <= rx & (pin_function_select_sel[p] != pfm_pkg::PIN_FUNCTION_SELECT_GPIO);
      end
    end
  end

  // Location select feeds each shared input from one pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_port0_clock_input   <= 1'b0;
      modem_dataset_ready_input  <= 1'b0;
      modem_carrier_detect_input <= 1'b0;
      modem_ring_input           <= 1'b0;
    end else begin
      serial_port0_clock_input   <= pfm_loc_pick(pfm_pkg::LOC_SCK_PINS,
                                      input_location_select[1:0], pad_in);
      modem_dataset_ready_input  <= pfm_loc_pick(pfm_pkg::LOC_DSR_PINS,
                                      input_location_select[3:2], pad_in);
      modem_carrier_detect_input <= pfm_loc_pick(pfm_pkg::LOC_DCD_PINS,
                                      input_location_select[5:4], pad_in);
      modem_ring_input           <= pfm_loc_pick(pfm_pkg::LOC_RI_PINS,
                                      input_location_select[7:6], pad_in);
    end
  end

endmodule

// [tb/pfm_pad_config_monitor.sv]
`timescale 1ns/1ps
module pfm_pad_config_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [7:0] pad_pull_up_en,
  input wire logic [7:0] pad_pull_down_en,
  input wire logic [7:0] pad_hyst_en,
  input wire logic [7:0] pad_rx_en,
  input wire logic [7:0] pad_filter_en,
  input wire logic [7:0] pad_high_sink_en,
  input wire logic [7:0] pad_analog_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_reset_pullup;
    $rose(rst_n) |=> pad_pull_up_en == 8'hff && pad_rx_en == 8'hff;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup) else $error("reset pull wrong");
  // Keeper must never fight itself
  property p_pull_excl;
    (pad_pull_up_en & pad_pull_down_en) == 8'h00;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_analog_rx;
    pad_analog_en[7] |-> !pad_rx_en[7] && !pad_hyst_en[7];
  endproperty
  a_analog_rx: assert property (p_analog_rx) else $error("receiver on in analog");
  property p_analog_ign;
    pad_analog_en[7] |-> !pad_pull_up_en[7] && !pad_pull_down_en[7];
  endproperty
  a_analog_ign: assert property (p_analog_ign) else $error("pull on in analog");
  property p_analog_only;
    pad_analog_en[6:0] == 7'h00;
  endproperty
  a_analog_only: assert property (p_analog_only) else $error("analog on digital pin");
  property p_sink_pins;
    (pad_high_sink_en & 8'h9f) == 8'h00 && (pad_filter_en & 8'h9f) == 8'h00;
  endproperty
  a_sink_pins: assert property (p_sink_pins) else $error("i2c pad on other pin");
  property p_sink_filter;
    (pad_high_sink_en & ~pad_filter_en) == 8'h00;
  endproperty
  a_sink_filter: assert property (p_sink_filter) else $error("sink without filter");
endmodule
bind pfm_pad_config pfm_pad_config_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .pad_pull_up_en(pad_pull_up_en), .pad_pull_down_en(pad_pull_down_en),
  .pad_hyst_en(pad_hyst_en), .pad_rx_en(pad_rx_en), .pad_filter_en(pad_filter_en),
  .pad_high_sink_en(pad_high_sink_en), .pad_analog_en(pad_analog_en));

// [tb/pfm_pad_model.sv]
`timescale 1ns/1ps
module pfm_pad_model (
  input wire logic       clk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_down,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_level,
  output logic [7:0]     pad_in
);
  logic [7:0] float_v = 8'h00;
  // A pad nobody holds wanders, so no stale level can pass for retention
  always_ff @(posedge clk) begin
    float_v <= ~pad_in;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_level[i] :
                  pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : float_v[i];
    end
  end
endmodule

// [tb/pfm_pad_config_tb.sv]
`timescale 1ns/1ps
module pfm_pad_config_tb;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, deep_power_down;
  logic        sck, dsr, dcd, ri;
  logic [7:0]  avs_address, pad_in, pad_out, pad_oe_n, pu, pd, hy, rx, flt, snk, ana;
  logic [7:0]  gpio_in, periph_in, ext_en, ext_level, d, v;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [23:0] periph_out, periph_oe;
  int          err_total, tests_run, f;
  int          cfg_m[8];
  int          off[8] = '{'h00, 'h08, 'h0c, 'h10, 'h14, 'h30, 'h34, 'h6c};
  int          loc[4][4] = '{'{1, 4, 7, 1}, '{2, 2, 3, 2}, '{3, 4, 0, 3}, '{0, 0, 2, 0}};
  pfm_pad_config dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .deep_power_down, .pad_in, .pad_out,
    .pad_oe_n, .pad_pull_up_en(pu), .pad_pull_down_en(pd), .pad_hyst_en(hy), .pad_rx_en(rx),
    .pad_filter_en(flt), .pad_high_sink_en(snk), .pad_analog_en(ana), .gpio_in, .periph_out,
    .periph_oe, .periph_in, .serial_port0_clock_input(sck), .modem_dataset_ready_input(dsr),
    .modem_carrier_detect_input(dcd), .modem_ring_input(ri));
  pfm_pad_model u_pads (.clk, .pad_out, .pad_oe_n, .pull_up(pu), .pull_down(pd), .ext_en,
    .ext_level, .pad_in);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One idle edge first, so a released strobe is never raised again in the same step
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      err_total++;
      stop_test();
    end
  endtask
  // Model of what a config register reads back after a full-word write
  function automatic int cfg_exp(int p, logic [31:0] wd);
    return {22'h0, (p == 5 || p == 6) ? wd[9:8] : 2'b00, (p == 7) ? wd[7] : 1'b1, 1'b1, wd[5:0]};
  endfunction
  task automatic wcfg(int p, logic [31:0] wd);
    bus(1'b1, off[p][7:0], wd);
    cfg_m[p] = cfg_exp(p, wd);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    tick(6);
    rst_n <= 1'b1;
    for (int p = 0; p < 8; p++) cfg_m[p] = 'hd0;
    tick(2);
    chk("pull_up", pu, 8'hff);
    bus(1'b0, 8'h04, 0); chk("rsvd", q, 0);
    bus(1'b0, 8'hf0, 0); chk("unmapped", q, 0);
  endtask
  task automatic readback();
    for (int p = 0; p < 8; p++) begin
      bus(1'b0, off[p][7:0], 0); chk("cfg", q, cfg_m[p]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {avs_read, avs_write, deep_power_down, avs_address, avs_writedata} = '0;
    {err_total, tests_run, ext_en, ext_level} = '0;
    avs_byteenable = 4'hf;
    rst_n = 1'b0;
    void'($urandom(32'h3ed131ae));
    periph_out = 24'($urandom);
    periph_oe  = 24'($urandom);
    do_reset();
    readback();
    $display("reset test done");
    // Random contents, unmapped write, then a second reset
    for (int p = 0; p < 8; p++) wcfg(p, $urandom & 32'hfffffdff);
    bus(1'b1, 8'hf4, $urandom);
    readback();
    do_reset();
    readback();
    $display("register test done");
    // GPIO direction, then a peripheral takes pin 0
    for (int p = 0; p < 5; p++) wcfg(p, 0);
    d = 8'($urandom);
    v = 8'($urandom);
    bus(1'b1, 8'hc0, {24'h0, d});
    bus(1'b1, 8'hc4, {24'h0, v});
    tick(3);
    chk("oe_n", pad_oe_n[4:0], 5'(~d[4:0]));
    chk("out", pad_out[4:0] & d[4:0], v[4:0] & d[4:0]);
    chk("periph_in", periph_in[4:0], 0);
    f = 1 + $urandom % 3;
    // Pull-up keeps an undriven pin steady for the receive check
    wcfg(0, f | 'h10);
    bus(1'b1, 8'hc0, {24'h0, ~d});
    tick(3);
    chk("oe_n", pad_oe_n[0], !periph_oe[f-1]);
    chk("periph_in", periph_in[0], pad_in[0]);
    wcfg(0, 5);
    tick(3);
    chk("oe_n", pad_oe_n[0], 1'b1);
    $display("function test done");
    // Pull modes and the keeper on input pin 1
    bus(1'b1, 8'hc0, 0);
    for (int m = 0; m < 3; m++) begin
      wcfg(1, m << 3);
      tick(3);
      chk("pulls", {pu[1], pd[1]}, {m == 2, m == 1});
    end
    ext_en[1] <= 1'b1;
    ext_level[1] <= v[0];
    wcfg(1, 'h18);
    // Write lands at the answer edge; the keeper needs one more edge of the level
    tick(1);
    ext_en[1] <= 1'b0;
    tick(3);
    chk("keep", {pu[1], pd[1], pad_in[1]}, {v[0], !v[0], v[0]});
    deep_power_down <= 1'b1;
    tick(3);
    chk("keep_off", {pu[1], pd[1]}, 2'b00);
    deep_power_down <= 1'b0;
    $display("pull test done");
    // Analog mode on the converter pin, ignored elsewhere
    wcfg(0, 'h20);
    wcfg(7, 'h38);
    tick(3);
    chk("pin0", {ana[0], rx[0], hy[0]}, 3'b011);
    chk("pin7", {ana[7], rx[7], hy[7], pu[7], pd[7], gpio_in[7]}, 6'h20);
    readback();
    // I2C modes on the clock pin
    for (int m = 0; m < 3; m++) begin
      wcfg(5, 1 | (m << 8));
      tick(3);
      chk("i2c", {flt[5], snk[5]}, {m != 1, m == 2});
    end
    $display("mode test done");
    // Input location select
    for (int p = 0; p < 8; p++) wcfg(p, (p == 7) ? 'h80 : 0);
    bus(1'b1, 8'hc0, 0);
    ext_en <= 8'hff;
    ext_level <= v;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'hb0, {24'h0, {4{c[1:0]}}});
      tick(3);
      chk("loc", {sck, dsr, dcd, ri}, {v[loc[0][c]], v[loc[1][c]], v[loc[2][c]], v[loc[3][c]]});
    end
    bus(1'b0, 8'hc8, 0); chk("state", q, {24'h0, v});
    chk("gpio_in", gpio_in, v);
    $display("location test done");
    stop_test();
  end
endmodule
